/* File: rtp_counter_tick.sv */
// real-time counter with period wrap, compare match, ppm trim and periodic tick timer
// assumes the four slow clock sources arrive as one-cycle enable pulses synchronous to clk
`timescale 1ns/1ns

// Overview of operation
// - sign bit zero slows the prescaler; sign bit one speeds it up only when the prescaler field is nonzero
// - error magnitude bits 6:0 give correction clocks per million slow cycles
// - two-bit selector picks one of four slow clock sources
// - counter read-write as low and high byte, resets to zero
// - counter write lands two slow cycles later; busy flag shows pending
// - period resets to all ones, lands two slow cycles later, busy flag
// - compare value read-write as two bytes, resets to zero
// - tick interval code 1 to 14 gives 4 to 32768 cycles; 0 none
// - tick control bit 0 turns the tick timer on; resets to zero
// - tick status bit 0 is one while tick control is synchronising
// - tick interrupt enable gates the tick flag onto the request
// - tick sets the flag; writing one clears it, zero leaves it
// - debug halt stops the tick timer unless run-when-halted is set
// - counter at period wraps to zero and sets wrap flag, write one clears
// - counter equal to compare sets match flag, write one clears
// - prescaler field divides slow clock by two to the field value
// - trim acts only while trim apply enable is set
module rtp_counter_tick
  import rtp_pkg::*;
#(
  parameter logic [19:0] PPM_INTERVAL = rtp_pkg::PPM_INTERVAL_DEFAULT
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // avalon-mm slave
  input  wire rtp_pkg::rtp_av_req_t  av_req,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  // slow clock sources and debug
  input  wire rtp_pkg::rtp_clk_src_t clk_src,
  input  wire logic                  dbg_halt,
  // interrupt requests
  output logic                       rtc_irq,
  output logic                       tick_request_irq
);
  import rtp_pkg::*;

  rtp_state_t s_q;
  rtp_state_t s_d;

  function automatic logic [14:0] pow2_mask(input logic [3:0] code);
    logic [15:0] m;
    m = (16'h0001 << code) - 16'h0001;
    return m[14:0];
  endfunction

  logic        req;
  logic        done;
  logic [4:0]  idx;
  logic        slow_tick;
  logic        rtc_run;
  logic        pit_run;
  logic        trim_on;
  logic [1:0]  step;
  logic [14:0] psc_mask;
  logic [15:0] psc_sum;
  logic        cnt_tick;
  logic [3:0]  pit_code;
  logic [14:0] pit_mask;
  logic        pit_tick;
  logic [15:0] cnt_inc;
  logic        at_top;

  assign req  = av_req.read | av_req.write;
  assign done = req & ~s_q.stall;
  assign idx  = av_req.address[6:2];

  // source mux
  always_comb begin
    unique case (s_q.clock_source_select)
      SRC_INT_FAST: slow_tick = clk_src.internal_fast_low_osc;
      SRC_INT_KHZ:  slow_tick = clk_src.internal_kilohertz_osc;
      SRC_CRYSTAL:  slow_tick = clk_src.crystal_low_osc;
      SRC_EXT_PIN:  slow_tick = clk_src.external_pin_clock;
    endcase
  end

  assign rtc_run = slow_tick & s_q.ctrl_act[CTRL_ENABLE_BIT] & ~(dbg_halt & ~s_q.dbg);
  assign trim_on = s_q.ctrl_act[CTRL_TRIM_BIT] & (s_q.corr_left != 7'h00);
  // a positive correction swallows one prescaler step, a negative one adds a step
  assign step     = trim_on ? (s_q.trim[TRIM_SIGN_BIT] ? 2'h2 : 2'h0) : 2'h1;
  assign psc_mask = pow2_mask(s_q.ctrl_act[CTRL_PRESC_LSB +: 4]);
  assign psc_sum  = {1'b0, s_q.psc & psc_mask} + {14'h0000, step};
  assign cnt_tick = rtc_run & (psc_sum > {1'b0, psc_mask});
  assign cnt_inc  = s_q.cnt + 16'h0001;
  assign at_top   = (s_q.cnt == s_q.top_act);

  // tick timer uses the undivided slow clock
  assign pit_run  = slow_tick & s_q.pit_ctrl_act[PIT_ON_BIT] & ~(dbg_halt & ~s_q.pit_dbg);
  assign pit_code = s_q.pit_ctrl_act[PIT_CODE_LSB +: 4];
  assign pit_mask = pow2_mask(pit_code + 4'h1);
  // reserved and off codes never tick
  assign pit_tick = pit_run & (pit_code != PIT_CODE_OFF) & (pit_code != PIT_CODE_RESERVED)
                  & (&(s_q.pit_cnt | ~pit_mask));

  always_comb begin
    logic [15:0] wide;
    logic [7:0]  wd;
    logic        wr;
    logic [1:0]  irq_clr;
    logic        pit_clr;
    wide    = {s_q.temp, 8'h00};
    wd      = av_req.writedata[7:0];
    wr      = done & av_req.write & av_req.byteenable[0];
    irq_clr = 2'h0;
    pit_clr = 1'b0;
    s_d     = s_q;
    s_d.stall = ~(req & s_q.stall);

    // read data is registered one edge ahead of the completing edge
    s_d.rdata = 8'h00;
    if (req & s_q.stall & av_req.read) begin
      unique case (idx)
        IDX_CTRL:     s_d.rdata = s_q.ctrl;
        IDX_STATUS:   s_d.rdata = {4'h0, s_q.busy[3:0]};
        IDX_IRQ_EN:   s_d.rdata = {6'h00, s_q.irq_en};
        IDX_IRQ_FLAG: s_d.rdata = {6'h00, s_q.irq_flag};
        IDX_TEMP:     s_d.rdata = s_q.temp;
        IDX_DBG:      s_d.rdata = {7'h00, s_q.dbg};
        IDX_TRIM:     s_d.rdata = s_q.trim;
        IDX_CLOCK_SOURCE_SELECT:   s_d.rdata = {6'h00, s_q.clock_source_select};
        IDX_CNT_LO:   s_d.rdata = s_q.cnt[7:0];
        IDX_TOP_LO:   s_d.rdata = s_q.top[7:0];
        IDX_MATCH_LO: s_d.rdata = s_q.match[7:0];
        IDX_CNT_HI, IDX_TOP_HI, IDX_MATCH_HI: s_d.rdata = s_q.temp;
        IDX_PIT_CTRL: s_d.rdata = s_q.pit_ctrl;
        IDX_PIT_SYNC: s_d.rdata = {7'h00, s_q.busy[BUSY_PIT]};
        IDX_PIT_IE:   s_d.rdata = {7'h00, s_q.pit_ie};
        IDX_PIT_FLAG: s_d.rdata = {7'h00, s_q.pit_flag};
        IDX_PIT_DBG:  s_d.rdata = {7'h00, s_q.pit_dbg};
        default:      s_d.rdata = 8'h00;
      endcase
    end

    // low-byte read snapshots the high byte at the edge that samples the low byte,
    // so a count tick between the two edges cannot split the pair
    if (req & s_q.stall & av_req.read) begin
      unique case (idx)
        IDX_CNT_LO:   s_d.temp = s_q.cnt[15:8];
        IDX_TOP_LO:   s_d.temp = s_q.top[15:8];
        IDX_MATCH_LO: s_d.temp = s_q.match[15:8];
        default:      s_d.temp = s_q.temp;
      endcase
    end

    // slow-domain synchronisation: two slow ticks from write to effect
    for (int i = 0; i < NUM_SYNC; i++) begin
      if (s_q.busy[i] && slow_tick) begin
        if (s_q.sync[i] == SYNC_LAST) begin
          s_d.busy[i] = 1'b0;
          s_d.sync[i] = 2'h0;
        end else begin
          s_d.sync[i] = s_q.sync[i] + 2'h1;
        end
      end
    end
    if (s_q.busy[BUSY_CTRL] && !s_d.busy[BUSY_CTRL]) begin
      s_d.ctrl_act = s_q.ctrl;
    end
    if (s_q.busy[BUSY_TOP] && !s_d.busy[BUSY_TOP]) begin
      s_d.top_act = s_q.top;
    end
    if (s_q.busy[BUSY_MATCH] && !s_d.busy[BUSY_MATCH]) begin
      s_d.match_act = s_q.match;
    end
    if (s_q.busy[BUSY_PIT] && !s_d.busy[BUSY_PIT]) begin
      s_d.pit_ctrl_act = s_q.pit_ctrl;
    end

    // ppm window: load the correction budget at each window start
    if (rtc_run) begin
      if (s_q.ppm == PPM_INTERVAL - 20'h0_0001) begin
        s_d.ppm       = 20'h0_0000;
        s_d.corr_left = s_q.ctrl_act[CTRL_TRIM_BIT] ? s_q.trim[6:0] : 7'h00;
      end else begin
        s_d.ppm = s_q.ppm + 20'h0_0001;
        if (trim_on) begin
          s_d.corr_left = s_q.corr_left - 7'h01;
        end
      end
      s_d.psc = psc_sum[14:0] & psc_mask;
    end

    // counting, wrap and match
    if (cnt_tick) begin
      if (at_top) begin
        s_d.cnt = 16'h0000;
      end else begin
        s_d.cnt = cnt_inc;
      end
    end
    if (s_q.busy[BUSY_CNT] && !s_d.busy[BUSY_CNT]) begin
      s_d.cnt = s_q.cnt_wr;
    end

    if (pit_run) begin
      s_d.pit_cnt = s_q.pit_cnt + 15'h0001;
    end

    // register writes
    if (wr) begin
      unique case (idx)
        IDX_CTRL: begin
          s_d.ctrl = wd;
          s_d.busy[BUSY_CTRL] = 1'b1;
          s_d.sync[BUSY_CTRL] = 2'h0;
        end
        IDX_IRQ_EN:   s_d.irq_en = wd[1:0];
        IDX_IRQ_FLAG: irq_clr = wd[1:0];
        IDX_TEMP:     s_d.temp = wd;
        IDX_DBG:      s_d.dbg = wd[0];
        IDX_TRIM:     s_d.trim = wd;
        IDX_CLOCK_SOURCE_SELECT:   s_d.clock_source_select = wd[1:0];
        IDX_CNT_LO, IDX_TOP_LO, IDX_MATCH_LO: s_d.temp = wd;
        IDX_CNT_HI: begin
          s_d.cnt_wr = {wd, s_q.temp};
          s_d.busy[BUSY_CNT] = 1'b1;
          s_d.sync[BUSY_CNT] = 2'h0;
        end
        IDX_TOP_HI: begin
          s_d.top = {wd, s_q.temp};
          s_d.busy[BUSY_TOP] = 1'b1;
          s_d.sync[BUSY_TOP] = 2'h0;
        end
        IDX_MATCH_HI: begin
          s_d.match = {wd, s_q.temp};
          s_d.busy[BUSY_MATCH] = 1'b1;
          s_d.sync[BUSY_MATCH] = 2'h0;
        end
        IDX_PIT_CTRL: begin
          s_d.pit_ctrl = {1'b0, wd[6:3], 2'h0, wd[0]};
          s_d.busy[BUSY_PIT] = 1'b1;
          s_d.sync[BUSY_PIT] = 2'h0;
        end
        IDX_PIT_IE:   s_d.pit_ie = wd[0];
        IDX_PIT_FLAG: pit_clr = wd[0];
        IDX_PIT_DBG:  s_d.pit_dbg = wd[0];
        default:      s_d.temp = s_d.temp;
      endcase
    end

    // hardware set beats a software clear in the same cycle
    wide = cnt_tick ? (at_top ? 16'h0000 : cnt_inc) : s_q.cnt;
    s_d.irq_flag[WRAP_BIT]  = (s_q.irq_flag[WRAP_BIT] & ~irq_clr[WRAP_BIT]) | (cnt_tick & at_top);
    s_d.irq_flag[MATCH_BIT] = (s_q.irq_flag[MATCH_BIT] & ~irq_clr[MATCH_BIT])
                            | (cnt_tick & (wide == s_q.match_act));
    s_d.pit_flag = (s_q.pit_flag & ~pit_clr) | pit_tick;
    s_d.rtc_irq  = |(s_d.irq_flag & s_d.irq_en);
    s_d.pit_irq  = s_d.pit_flag & s_d.pit_ie;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q              <= '0;
      s_q.stall        <= 1'b1;
      s_q.cnt          <= CNT_RESET;
      s_q.cnt_wr       <= CNT_RESET;
      s_q.top          <= TOP_RESET;
      s_q.top_act      <= TOP_RESET;
      s_q.match        <= MATCH_RESET;
      s_q.match_act    <= MATCH_RESET;
      s_q.ctrl         <= BYTE_RESET;
      s_q.pit_ctrl     <= BYTE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata     = {24'h00_0000, s_q.rdata};
  assign avs_waitrequest  = s_q.stall;
  assign rtc_irq          = s_q.rtc_irq;
  assign tick_request_irq = s_q.pit_irq;

  property p_cnt_sync;
    @(posedge clk) disable iff (sys_rst)
      (s_q.busy[BUSY_CNT] && slow_tick && s_q.sync[BUSY_CNT] == SYNC_LAST && !(done && av_req.write))
      |=> (!s_q.busy[BUSY_CNT] && s_q.cnt == $past(s_q.cnt_wr));
  endproperty
  a_cnt_sync: assert property (p_cnt_sync) else $error("counter write not applied on second slow tick");

  property p_pit_busy;
    @(posedge clk) disable iff (sys_rst)
      (done && av_req.write && av_req.byteenable[0] && idx == IDX_PIT_CTRL) |=> s_q.busy[BUSY_PIT];
  endproperty
  a_pit_busy: assert property (p_pit_busy) else $error("tick control busy not raised");

  property p_pit_flag_set;
    @(posedge clk) disable iff (sys_rst) pit_tick |=> s_q.pit_flag;
  endproperty
  a_pit_flag_set: assert property (p_pit_flag_set) else $error("tick flag lost");

  property p_pit_irq_gate;
    @(posedge clk) disable iff (sys_rst) !s_q.pit_ie |-> !tick_request_irq;
  endproperty
  a_pit_irq_gate: assert property (p_pit_irq_gate) else $error("tick request without enable");

  property p_reserved;
    @(posedge clk) disable iff (sys_rst) (pit_code == PIT_CODE_RESERVED) |-> !pit_tick;
  endproperty
  a_reserved: assert property (p_reserved) else $error("tick issued on reserved code");

  property p_wrap;
    @(posedge clk) disable iff (sys_rst)
      (cnt_tick && at_top && !s_q.busy[BUSY_CNT]) |=> (s_q.cnt == 16'h0000 && s_q.irq_flag[WRAP_BIT]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap at period");

  property p_match;
    @(posedge clk) disable iff (sys_rst)
      (cnt_tick && !at_top && cnt_inc == s_q.match_act) |=> s_q.irq_flag[MATCH_BIT];
  endproperty
  a_match: assert property (p_match) else $error("match flag not set");

  property p_halt;
    @(posedge clk) disable iff (sys_rst) (dbg_halt && !s_q.pit_dbg) |-> !pit_tick;
  endproperty
  a_halt: assert property (p_halt) else $error("tick during debug halt");

  property p_temp;
    @(posedge clk) disable iff (sys_rst)
      (req && s_q.stall && av_req.read && idx == IDX_CNT_LO) |=> s_q.temp == $past(s_q.cnt[15:8]);
  endproperty
  a_temp: assert property (p_temp) else $error("high byte not latched on low read");

  property p_top_sync;
    @(posedge clk) disable iff (sys_rst)
      (s_q.busy[BUSY_TOP] && slow_tick && s_q.sync[BUSY_TOP] == SYNC_LAST && !(done && av_req.write))
      |=> (!s_q.busy[BUSY_TOP] && s_q.top_act == $past(s_q.top));
  endproperty
  a_top_sync: assert property (p_top_sync) else $error("period write not applied on second slow tick");

  property p_pit_sync;
    @(posedge clk) disable iff (sys_rst)
      (s_q.busy[BUSY_PIT] && slow_tick && s_q.sync[BUSY_PIT] == SYNC_LAST && !(done && av_req.write))
      |=> (!s_q.busy[BUSY_PIT] && s_q.pit_ctrl_act == $past(s_q.pit_ctrl));
  endproperty
  a_pit_sync: assert property (p_pit_sync) else $error("tick control not applied on second slow tick");

  property p_flag_clear;
    @(posedge clk) disable iff (sys_rst)
      (done && av_req.write && av_req.byteenable[0] && idx == IDX_PIT_FLAG && av_req.writedata[0] && !pit_tick)
      |=> !s_q.pit_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("tick flag not cleared by write one");

  property p_flag_keep;
    @(posedge clk) disable iff (sys_rst)
      (done && av_req.write && idx == IDX_PIT_FLAG && !av_req.writedata[0] && s_q.pit_flag)
      |=> s_q.pit_flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("tick flag lost on write zero");

  property p_wrap_clear;
    @(posedge clk) disable iff (sys_rst)
      (done && av_req.write && av_req.byteenable[0] && idx == IDX_IRQ_FLAG && av_req.writedata[WRAP_BIT]
       && !(cnt_tick && at_top)) |=> !s_q.irq_flag[WRAP_BIT];
  endproperty
  a_wrap_clear: assert property (p_wrap_clear) else $error("wrap flag not cleared by write one");

  // a positive correction must hold the prescaler where it stands for that slow tick
  property p_step;
    @(posedge clk) disable iff (sys_rst)
      (rtc_run && trim_on && !s_q.trim[TRIM_SIGN_BIT])
      |=> (s_q.psc == $past(s_q.psc & psc_mask));
  endproperty
  a_step: assert property (p_step) else $error("prescaler advanced on positive correction");

  c_pit_tick: cover property (@(posedge clk) disable iff (sys_rst) pit_tick);
  c_wrap:     cover property (@(posedge clk) disable iff (sys_rst) cnt_tick && at_top);
  c_match:    cover property (@(posedge clk) disable iff (sys_rst) s_q.irq_flag[MATCH_BIT]);
  c_trim:     cover property (@(posedge clk) disable iff (sys_rst) rtc_run && trim_on);
  c_halt:     cover property (@(posedge clk) disable iff (sys_rst) dbg_halt && pit_run);
endmodule

/* File: rtp_pkg.sv */
// package for the real-time counter and periodic tick block: register map, fields, reset values, types
// assumes a byte-wide register view placed one register per 32-bit Avalon word
package rtp_pkg;

  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_CTRL      = 5'h00;
  localparam logic [4:0] IDX_STATUS    = 5'h01;
  localparam logic [4:0] IDX_IRQ_EN    = 5'h02;
  localparam logic [4:0] IDX_IRQ_FLAG  = 5'h03;
  localparam logic [4:0] IDX_TEMP      = 5'h04;
  localparam logic [4:0] IDX_DBG       = 5'h05;
  localparam logic [4:0] IDX_TRIM      = 5'h06;
  localparam logic [4:0] IDX_CLOCK_SOURCE_SELECT    = 5'h07;
  localparam logic [4:0] IDX_CNT_LO    = 5'h08;
  localparam logic [4:0] IDX_CNT_HI    = 5'h09;
  localparam logic [4:0] IDX_TOP_LO    = 5'h0a;
  localparam logic [4:0] IDX_TOP_HI    = 5'h0b;
  localparam logic [4:0] IDX_MATCH_LO  = 5'h0c;
  localparam logic [4:0] IDX_MATCH_HI  = 5'h0d;
  localparam logic [4:0] IDX_PIT_CTRL  = 5'h10;
  localparam logic [4:0] IDX_PIT_SYNC  = 5'h11;
  localparam logic [4:0] IDX_PIT_IE    = 5'h12;
  localparam logic [4:0] IDX_PIT_FLAG  = 5'h13;
  localparam logic [4:0] IDX_PIT_DBG   = 5'h15;

  // reset values
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] TOP_RESET   = 16'hffff;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_TRIM_BIT   = 2;
  localparam int CTRL_PRESC_LSB  = 3;
  localparam int TRIM_SIGN_BIT   = 7;
  localparam int PIT_ON_BIT      = 0;
  localparam int PIT_CODE_LSB    = 3;
  localparam int WRAP_BIT        = 0;
  localparam int MATCH_BIT       = 1;

  // synchronisation busy slots; the low four match the status register layout
  localparam int BUSY_CTRL  = 0;
  localparam int BUSY_CNT   = 1;
  localparam int BUSY_TOP   = 2;
  localparam int BUSY_MATCH = 3;
  localparam int BUSY_PIT   = 4;
  localparam int NUM_SYNC   = 5;

  // two slow-clock cycles from update to effect
  localparam logic [1:0] SYNC_LAST = 2'h1;

  localparam logic [3:0] PIT_CODE_OFF      = 4'h0;
  localparam logic [3:0] PIT_CODE_RESERVED = 4'hf;

  // slow clock sources
  localparam logic [1:0] SRC_INT_FAST = 2'h0;
  localparam logic [1:0] SRC_INT_KHZ  = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL  = 2'h2;
  localparam logic [1:0] SRC_EXT_PIN  = 2'h3;

  // correction window in slow cycles
  localparam logic [19:0] PPM_INTERVAL_DEFAULT = 20'hf_4240;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [6:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } rtp_av_req_t;

  typedef struct packed {
    logic internal_fast_low_osc;
    logic internal_kilohertz_osc;
    logic crystal_low_osc;
    logic external_pin_clock;
  } rtp_clk_src_t;

  typedef struct packed {
    logic                     stall;
    logic [7:0]               rdata;
    logic [7:0]               ctrl;
    logic [7:0]               ctrl_act;
    logic [1:0]               irq_en;
    logic [1:0]               irq_flag;
    logic [7:0]               temp;
    logic                     dbg;
    logic [7:0]               trim;
    logic [1:0]               clock_source_select;
    logic [15:0]              cnt;
    logic [15:0]              cnt_wr;
    logic [15:0]              top;
    logic [15:0]              top_act;
    logic [15:0]              match;
    logic [15:0]              match_act;
    logic [7:0]               pit_ctrl;
    logic [7:0]               pit_ctrl_act;
    logic                     pit_ie;
    logic                     pit_flag;
    logic                     pit_dbg;
    logic [NUM_SYNC-1:0]      busy;
    logic [NUM_SYNC-1:0][1:0] sync;
    logic [14:0]              psc;
    logic [14:0]              pit_cnt;
    logic [19:0]              ppm;
    logic [6:0]               corr_left;
    logic                     rtc_irq;
    logic                     pit_irq;
  } rtp_state_t;

endpackage

/* File: tb_rtc_counter_and_periodic_tick.sv */
// self-checking bench for the real-time counter and periodic tick block
// assumes one wait state per Avalon access and slow clock edges given as one-cycle pulses
`timescale 1ns/1ns
module tb_rtc_counter_and_periodic_tick;
  import rtp_pkg::*;
  logic         clk;
  logic         sys_rst;
  rtp_av_req_t  av_req;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  rtp_clk_src_t clk_src;
  logic         dbg_halt;
  logic         rtc_irq;
  logic         tick_request_irq;
  int           err_total;
  int           comparisons;
  logic [1:0]   src;
  logic [7:0]   rv;
  logic [15:0]  c0;
  logic [15:0]  c1;

  // short correction window so whole windows fit in a short run
  rtp_counter_tick #(.PPM_INTERVAL(20'h0_0040)) dut (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .av_req           (av_req),
    .avs_readdata     (avs_readdata),
    .avs_waitrequest  (avs_waitrequest),
    .clk_src          (clk_src),
    .dbg_halt         (dbg_halt),
    .rtc_irq          (rtc_irq),
    .tick_request_irq (tick_request_irq)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    complete_run;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is seen low; read data taken at that same edge
  task automatic acc(input logic w, input logic [4:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    av_req <= '{read: !w, write: w, address: {i, 2'b00}, byteenable: 4'h1, writedata: {24'h00_0000, d}};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) err_total++;
    rv = avs_readdata[7:0];
    av_req <= '0;
  endtask

  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    acc(1'b1, i, d);
  endtask

  task automatic rdchk(input logic [4:0] i, input logic [7:0] e);
    acc(1'b0, i, 8'h00);
    chk({24'h00_0000, rv}, {24'h00_0000, e});
  endtask

  // low byte first: the low half travels through the shared latch
  task automatic wr16(input logic [4:0] i, input logic [15:0] v);
    wr(i, v[7:0]);
    wr(5'(i + 1), v[15:8]);
  endtask

  task automatic rd16(input logic [4:0] i, output logic [15:0] v);
    acc(1'b0, i, 8'h00);
    v[7:0] = rv;
    acc(1'b0, 5'(i + 1), 8'h00);
    v[15:8] = rv;
  endtask

  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      clk_src <= rtp_clk_src_t'(m);
      @(posedge clk);
      clk_src <= '0;
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic slow(input int n);
    pulse(4'b1000 >> src, n);
  endtask

  task automatic t_reset;
    logic [4:0] ri [13];
    logic [7:0] re [13];
    ri = '{IDX_TRIM, IDX_CLOCK_SOURCE_SELECT, IDX_CNT_LO, IDX_CNT_HI, IDX_TOP_LO, IDX_TOP_HI, IDX_MATCH_LO,
           IDX_MATCH_HI, IDX_PIT_CTRL, IDX_PIT_SYNC, IDX_PIT_IE, IDX_PIT_FLAG, IDX_PIT_DBG};
    re = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    chk({30'h0000_0000, rtc_irq, tick_request_irq}, 32'h0000_0000);
    for (int k = 0; k < 13; k++) rdchk(ri[k], re[k]);
    wr(5'h0e, 8'hff);
    rdchk(5'h0e, 8'h00);
  endtask

  task automatic t_sync;
    wr16(IDX_CNT_LO, 16'h1234);
    rdchk(IDX_STATUS, 8'h02);
    slow(1);
    rdchk(IDX_STATUS, 8'h02);
    slow(1);
    rdchk(IDX_STATUS, 8'h00);
    rd16(IDX_CNT_LO, c0);
    chk({16'h0000, c0}, 32'h0000_1234);
    rdchk(IDX_TEMP, 8'h12);
    wr16(IDX_TOP_LO, 16'h0005);
    rdchk(IDX_STATUS, 8'h04);
    slow(2);
    rdchk(IDX_STATUS, 8'h00);
    wr16(IDX_MATCH_LO, 16'h0003);
    rd16(IDX_MATCH_LO, c0);
    chk({16'h0000, c0}, 32'h0000_0003);
    wr16(IDX_CNT_LO, 16'h0000);
    slow(2);
    wr(IDX_TRIM, 8'h85);
    rdchk(IDX_TRIM, 8'h85);
  endtask

  task automatic t_wrap;
    wr(IDX_IRQ_EN, 8'h03);
    wr(IDX_CTRL, 8'h01);
    slow(2);
    c0 = 16'h0000;
    for (int k = 0; k < 12 && c0 !== 16'h0003; k++) begin
      slow(1);
      rd16(IDX_CNT_LO, c0);
    end
    rdchk(IDX_IRQ_FLAG, 8'h02);
    chk({31'h0000_0000, rtc_irq}, 32'h0000_0001);
    wr(IDX_IRQ_FLAG, 8'h02);
    rdchk(IDX_IRQ_FLAG, 8'h00);
    slow(2);
    rdchk(IDX_IRQ_FLAG, 8'h00);
    slow(1);
    rd16(IDX_CNT_LO, c0);
    chk({16'h0000, c0}, 32'h0000_0000);
    rdchk(IDX_IRQ_FLAG, 8'h01);
    wr(IDX_IRQ_FLAG, 8'h01);
    rdchk(IDX_IRQ_FLAG, 8'h00);
    wr16(IDX_TOP_LO, 16'hffff);
    slow(2);
  endtask

  // warm-up spans two windows, so the budget is loaded whatever the phase
  task automatic meas(input logic [7:0] ctl, input logic [7:0] tr, input int n, input logic [15:0] dlt);
    wr(IDX_TRIM, tr);
    wr(IDX_CTRL, ctl);
    slow(128);
    rd16(IDX_CNT_LO, c0);
    slow(n);
    rd16(IDX_CNT_LO, c1);
    chk({16'h0000, c1 - c0}, {16'h0000, dlt});
  endtask

  task automatic t_trim;
    meas(8'h09, 8'h00, 16, 16'h0008);
    meas(8'h01, 8'h03, 64, 16'h0040);
    meas(8'h05, 8'h03, 64, 16'h003d);
    meas(8'h0d, 8'h83, 128, 16'h0043);
  endtask

  task automatic t_source;
    wr(IDX_TRIM, 8'h00);
    wr(IDX_CTRL, 8'h01);
    slow(2);
    for (int s = 0; s < 4; s++) begin
      wr(IDX_CLOCK_SOURCE_SELECT, 8'(s));
      src = 2'(s);
      rdchk(IDX_CLOCK_SOURCE_SELECT, 8'(s));
      rd16(IDX_CNT_LO, c0);
      pulse(~(4'b1000 >> s), 4);
      slow(3);
      rd16(IDX_CNT_LO, c1);
      chk({16'h0000, c1 - c0}, 32'h0000_0003);
    end
  endtask

  task automatic t_tick;
    wr(IDX_PIT_IE, 8'h01);
    for (int code = 1; code < 4; code++) begin
      wr(IDX_PIT_CTRL, 8'((code << 3) | 1));
      rdchk(IDX_PIT_SYNC, 8'h01);
      slow(2);
      rdchk(IDX_PIT_SYNC, 8'h00);
      // drop the flag left from the previous interval so the search finds a fresh tick
      wr(IDX_PIT_FLAG, 8'h01);
      rv = 8'h00;
      for (int k = 0; k < 40 && rv !== 8'h01; k++) begin
        slow(1);
        acc(1'b0, IDX_PIT_FLAG, 8'h00);
      end
      chk({31'h0000_0000, tick_request_irq}, 32'h0000_0001);
      wr(IDX_PIT_FLAG, 8'h00);
      rdchk(IDX_PIT_FLAG, 8'h01);
      wr(IDX_PIT_FLAG, 8'h01);
      slow((2 << code) - 1);
      rdchk(IDX_PIT_FLAG, 8'h00);
      slow(1);
      rdchk(IDX_PIT_FLAG, 8'h01);
    end
    wr(IDX_PIT_IE, 8'h00);
    repeat (3) @(posedge clk);
    chk({31'h0000_0000, tick_request_irq}, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      wr(IDX_PIT_CTRL, k == 0 ? 8'h01 : 8'h79);
      slow(2);
      wr(IDX_PIT_FLAG, 8'h01);
      slow(40);
      rdchk(IDX_PIT_FLAG, 8'h00);
    end
  endtask

  task automatic t_debug;
    wr(IDX_PIT_CTRL, 8'h09);
    slow(2);
    wr(IDX_PIT_DBG, 8'h00);
    @(posedge clk);
    dbg_halt <= 1'b1;
    wr(IDX_PIT_FLAG, 8'h01);
    slow(12);
    rdchk(IDX_PIT_FLAG, 8'h00);
    wr(IDX_PIT_DBG, 8'h01);
    slow(4);
    rdchk(IDX_PIT_FLAG, 8'h01);
    @(posedge clk);
    dbg_halt <= 1'b0;
  endtask

  initial begin
    sys_rst = 1'b1;
    av_req = '0;
    clk_src = '0;
    dbg_halt = 1'b0;
    src = 2'h0;
    err_total = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_sync;
    t_wrap;
    t_trim;
    t_source;
    t_tick;
    t_debug;
    complete_run;
  end
endmodule
